//--- amc_defines.svh
// constants for the reference, power-down and conversion-mode control pair
`ifndef AMC_DEFINES_SVH
`define AMC_DEFINES_SVH

`define AMC_CFG_W 16
`define AMC_CFG_DEFAULT 16'h0006
`define AMC_MODE_SEL_BIT 1
`define AMC_INT_REF_EN_BIT 2
`define AMC_CNT_W 12
`define AMC_DUMMY_CONV 2'h2

`define AMC_CLK_NS 40
`define AMC_T_BIAS_NS 2000
`define AMC_T_REF_SETTLE_NS 100000
`define AMC_T_CONV_WARP_NS 600
`define AMC_T_CONV_NORM_NS 720
`define AMC_T_WARP_MAX_NS 40000

`define AMC_BIAS_CYC ((`AMC_T_BIAS_NS + `AMC_CLK_NS - 1) / `AMC_CLK_NS)
`define AMC_REF_SETTLE_CYC ((`AMC_T_REF_SETTLE_NS + `AMC_CLK_NS - 1) / `AMC_CLK_NS)
`define AMC_CONV_WARP_CYC ((`AMC_T_CONV_WARP_NS + `AMC_CLK_NS - 1) / `AMC_CLK_NS)
`define AMC_CONV_NORM_CYC ((`AMC_T_CONV_NORM_NS + `AMC_CLK_NS - 1) / `AMC_CLK_NS)
`define AMC_WARP_MAX_CYC (`AMC_T_WARP_MAX_NS / `AMC_CLK_NS)
`define AMC_WARP_KEEP_CYC (`AMC_WARP_MAX_CYC / 2)

`endif

//--- amc_pkg.sv
// types for the reference, power-down and conversion-mode control pair
package amc_pkg;
    typedef enum logic [3:0] {
        DEV_SLEEP = 4'b0001,
        DEV_SETTLE = 4'b0010,
        DEV_IDLE = 4'b0100,
        DEV_CONV = 4'b1000
    } amc_dev_st_t;

    typedef enum logic [4:0] {
        HST_SLEEP = 5'b00001,
        HST_WAKE = 5'b00010,
        HST_CFG = 5'b00100,
        HST_DUMMY = 5'b01000,
        HST_RUN = 5'b10000
    } amc_hst_st_t;

    typedef struct packed {
        amc_dev_st_t st;
        logic [11:0] cnt;
        logic [11:0] idle;
        logic start_q;
        logic sleep_q;
        logic [15:0] cfg_pend;
        logic [15:0] cfg_stage;
        logic [15:0] cfg_act;
        logic busy;
        logic [15:0] result;
        logic res_valid;
        logic late;
        logic [15:0] seq;
    } amc_dev_t;

    typedef struct packed {
        amc_hst_st_t st;
        logic [15:0] cfg;
        logic cfg_wr;
        logic start;
        logic [1:0] dummies;
        logic busy_q;
        logic dummy;
        logic [11:0] idle;
        logic [15:0] data;
        logic data_valid;
    } amc_hst_t;
endpackage

//--- amc_if.sv
// wires between the host controller and the converter control logic
`timescale 1ns/10ps
interface amc_if;
    logic power_down_input;
    logic core_reset_input;
    logic convert_start_input;
    logic cs_n;
    logic [15:0] cfg_word;
    logic cfg_write;
    logic ref_input_pin_grounded;
    logic busy;
    logic [15:0] result;
    logic result_valid;
    logic sdo_oe;
    logic ready;
    logic bandgap_on;
    logic ref_buffer_on;
    logic regulators_on;
    logic warp_late;
    logic ext_ref_drive;

    modport dev (
        input power_down_input, core_reset_input, convert_start_input, cs_n,
        input cfg_word, cfg_write, ref_input_pin_grounded, ext_ref_drive,
        output busy, result, result_valid, sdo_oe, ready,
        output bandgap_on, ref_buffer_on, regulators_on, warp_late
    );
    modport host (
        output power_down_input, core_reset_input, convert_start_input, cs_n,
        output cfg_word, cfg_write, ref_input_pin_grounded, ext_ref_drive,
        input busy, result, result_valid, sdo_oe, ready,
        input bandgap_on, ref_buffer_on, regulators_on, warp_late
    );
endinterface

//--- amc_dev.sv
// converter control end: reference choice, deep sleep, mode and config pipeline
//
// Summary of operation
// R1: reference enable cleared turns band gap off
// R2: band gap off keeps reference buffer on
// R3: host clears reference enable, grounds ref input
// R4: host drives ref pins only after buffer off
// R5: power-down high ignores starts, interface off
// R6: sleep powers regulators, reference down; settle after
// R7: power-down release resets core and config
// R8: host rewrites config, makes two dummy conversions
// R9: mode select at configuration bit one
// R10: warp mode has bounded conversion interval
// R11: normal mode unbounded interval
// R12: reset defaults to normal mode
// R13: normal busy time longer than warp
// R14: conversions only after bias settled
// R15: reference enable set drives internal reference
// R16: power-down or reset aborts, sdo off
// R17: config applies two conversions later
// R18: power-down is level sensitive
`timescale 1ns/10ps
`include "amc_defines.svh"
module amc_dev #(
    parameter int BIAS_CYC = `AMC_BIAS_CYC,
    parameter int REF_SETTLE_CYC = `AMC_REF_SETTLE_CYC,
    parameter int CONV_WARP_CYC = `AMC_CONV_WARP_CYC,
    parameter int CONV_NORM_CYC = `AMC_CONV_NORM_CYC,
    parameter int WARP_MAX_CYC = `AMC_WARP_MAX_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    amc_if.dev bus,
    output logic o_sleeping,
    output logic [15:0] o_cfg_active
);
    localparam logic [11:0] BIAS_LD = 12'(BIAS_CYC - 1);
    localparam logic [11:0] REF_LD = 12'(REF_SETTLE_CYC - 1);
    localparam logic [11:0] WARP_LD = 12'(CONV_WARP_CYC - 1);
    localparam logic [11:0] NORM_LD = 12'(CONV_NORM_CYC - 1);
    localparam logic [11:0] WARP_MAX = 12'(WARP_MAX_CYC);
    localparam logic [11:0] IDLE_SAT = 12'hFFF;
    localparam logic [15:0] CFG_DEF = `AMC_CFG_DEFAULT;

    localparam amc_pkg::amc_dev_t DEV_RST = '{
        st: amc_pkg::DEV_SETTLE,
        cnt: BIAS_LD,
        idle: 12'h000,
        start_q: 1'b0,
        sleep_q: 1'b0,
        cfg_pend: CFG_DEF,
        cfg_stage: CFG_DEF,
        cfg_act: CFG_DEF,
        busy: 1'b0,
        result: 16'h0000,
        res_valid: 1'b0,
        late: 1'b0,
        seq: 16'h0000
    };

    amc_pkg::amc_dev_t s_q;
    amc_pkg::amc_dev_t s_d;

    function automatic logic cfg_bit(input logic [15:0] cfg, input int pos);
        cfg_bit = cfg[pos];
    endfunction

    logic start_rise;
    logic awake;
    logic int_ref_en;
    logic normal_mode;

    assign start_rise = bus.convert_start_input & ~s_q.start_q;
    assign awake = (s_q.st != amc_pkg::DEV_SLEEP) & ~bus.power_down_input;
    assign int_ref_en = cfg_bit(s_q.cfg_act, `AMC_INT_REF_EN_BIT);
    assign normal_mode = cfg_bit(s_q.cfg_act, `AMC_MODE_SEL_BIT); // R9

    always_comb begin
        s_d = s_q;
        s_d.start_q = bus.convert_start_input;
        s_d.sleep_q = bus.power_down_input;
        if (bus.power_down_input) begin
            // level held: stays asleep with no timer, exit only on release
            s_d.st = amc_pkg::DEV_SLEEP; // R18
            s_d.busy = 1'b0; // R16
            s_d.res_valid = 1'b0; // R5
        end else if (s_q.sleep_q) begin
            // release resets the core; reference must recharge first
            s_d = DEV_RST; // R7
            s_d.start_q = bus.convert_start_input;
            s_d.cnt = REF_LD; // R6
        end else if (bus.core_reset_input) begin
            s_d.cfg_pend = CFG_DEF; // R12
            s_d.cfg_stage = CFG_DEF;
            s_d.cfg_act = CFG_DEF;
            s_d.busy = 1'b0; // R16
            s_d.res_valid = 1'b0;
            s_d.late = 1'b0;
            if (s_q.st == amc_pkg::DEV_CONV) begin
                s_d.st = amc_pkg::DEV_IDLE;
            end
        end else begin
            if (bus.cfg_write) begin
                s_d.cfg_pend = bus.cfg_word;
            end
            unique case (s_q.st)
                amc_pkg::DEV_SLEEP: begin
                    s_d.st = amc_pkg::DEV_SETTLE;
                    s_d.cnt = REF_LD; // R6
                end
                amc_pkg::DEV_SETTLE: begin
                    // starts are dropped until bias and reference are up
                    if (s_q.cnt == 12'h000) begin
                        s_d.st = amc_pkg::DEV_IDLE; // R14
                        s_d.idle = 12'h000;
                    end else begin
                        s_d.cnt = s_q.cnt - 12'h001;
                    end
                end
                amc_pkg::DEV_IDLE: begin
                    if (s_q.idle != IDLE_SAT) begin
                        s_d.idle = s_q.idle + 12'h001;
                    end
                    if (start_rise) begin
                        s_d.st = amc_pkg::DEV_CONV;
                        s_d.busy = 1'b1;
                        s_d.cnt = normal_mode ? NORM_LD : WARP_LD; // R13
                        // warp sample taken too late is flagged corrupt
                        s_d.late = ~normal_mode & (s_q.idle >= WARP_MAX); // R10 R11
                        s_d.idle = 12'h000;
                    end
                end
                amc_pkg::DEV_CONV: begin
                    // further starts ignored until end of conversion
                    if (s_q.cnt == 12'h000) begin
                        s_d.st = amc_pkg::DEV_IDLE;
                        s_d.busy = 1'b0;
                        s_d.result = s_q.seq;
                        s_d.seq = s_q.seq + 16'h0001;
                        s_d.res_valid = 1'b1;
                        // a write after this edge waits one more conversion
                        s_d.cfg_stage = s_q.cfg_pend; // R17
                        s_d.cfg_act = s_q.cfg_stage; // R17
                    end else begin
                        s_d.cnt = s_q.cnt - 12'h001;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            s_q <= DEV_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.busy = s_q.busy;
    assign bus.result = s_q.result;
    assign bus.result_valid = s_q.res_valid;
    assign bus.warp_late = s_q.late;
    assign bus.ready = awake & (s_q.st == amc_pkg::DEV_IDLE) & ~bus.core_reset_input;
    // output driver only while awake, not in reset, chip selected
    assign bus.sdo_oe = awake & ~bus.core_reset_input & ~bus.cs_n; // R5 R16
    assign bus.regulators_on = awake; // R6
    assign bus.bandgap_on = awake & int_ref_en; // R1 R15
    // while awake, buffer off only when enable clear and the input strapped low
    assign bus.ref_buffer_on = awake & (int_ref_en | ~bus.ref_input_pin_grounded); // R2 R3
    assign o_sleeping = ~awake;
    assign o_cfg_active = s_q.cfg_act;
endmodule

//--- amc_host.sv
// host controller end: drives sleep, reset, starts and configuration
`timescale 1ns/10ps
`include "amc_defines.svh"
module amc_host #(
    parameter int WARP_KEEP_CYC = `AMC_WARP_KEEP_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    amc_if.host bus,
    input wire logic i_sleep,
    input wire logic i_core_reset,
    input wire logic i_conv_req,
    input wire logic [15:0] i_cfg,
    input wire logic i_cfg_wr,
    input wire logic i_ext_ref,
    input wire logic i_cs_n,
    output logic o_trusted,
    output logic [15:0] o_data,
    output logic o_data_valid
);
    localparam logic [11:0] KEEP = 12'(WARP_KEEP_CYC);
    localparam logic [15:0] CFG_DEF = `AMC_CFG_DEFAULT;

    localparam amc_pkg::amc_hst_t HST_RST = '{
        st: amc_pkg::HST_WAKE,
        cfg: CFG_DEF,
        cfg_wr: 1'b0,
        start: 1'b0,
        dummies: 2'h0,
        busy_q: 1'b0,
        dummy: 1'b0,
        idle: 12'h000,
        data: 16'h0000,
        data_valid: 1'b0
    };

    amc_pkg::amc_hst_t s_q;
    amc_pkg::amc_hst_t s_d;

    logic eoc;
    logic can_start;
    logic warp;

    assign eoc = s_q.busy_q & ~bus.busy;
    assign can_start = bus.ready & ~bus.busy & ~s_q.start & ~bus.core_reset_input;
    assign warp = ~s_q.cfg[`AMC_MODE_SEL_BIT];

    always_comb begin
        s_d = s_q;
        s_d.cfg_wr = 1'b0;
        s_d.start = 1'b0;
        s_d.data_valid = 1'b0;
        s_d.busy_q = bus.busy;
        if (i_cfg_wr) begin
            s_d.cfg = i_cfg;
        end
        if (s_q.idle != 12'hFFF) begin
            s_d.idle = s_q.idle + 12'h001;
        end
        if (i_sleep) begin
            s_d.st = amc_pkg::HST_SLEEP;
        end else begin
            unique case (s_q.st)
                amc_pkg::HST_SLEEP: begin
                    s_d.st = amc_pkg::HST_WAKE;
                end
                amc_pkg::HST_WAKE: begin
                    if (bus.ready) begin
                        s_d.st = amc_pkg::HST_CFG;
                    end
                end
                amc_pkg::HST_CFG: begin
                    s_d.cfg_wr = 1'b1; // R8
                    s_d.dummies = 2'h0;
                    s_d.st = amc_pkg::HST_DUMMY;
                end
                amc_pkg::HST_DUMMY: begin
                    if (i_cfg_wr) begin
                        s_d.st = amc_pkg::HST_CFG;
                    end else if (eoc && s_q.dummies == `AMC_DUMMY_CONV - 2'h1) begin
                        s_d.st = amc_pkg::HST_RUN; // R8 R17
                    end else if (can_start) begin
                        s_d.start = 1'b1;
                        s_d.idle = 12'h000;
                    end
                    if (eoc) begin
                        s_d.dummies = s_q.dummies + 2'h1;
                    end
                end
                amc_pkg::HST_RUN: begin
                    s_d.cfg_wr = i_cfg_wr;
                    if (eoc && !s_q.dummy) begin
                        s_d.data = bus.result;
                        s_d.data_valid = bus.result_valid;
                    end
                    if (can_start && (i_conv_req || (warp && s_q.idle >= KEEP))) begin
                        // keep-alive start in warp so no result goes stale
                        s_d.start = 1'b1; // R10
                        s_d.dummy = ~i_conv_req;
                        s_d.idle = 12'h000;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            s_q <= HST_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.power_down_input = i_sleep;
    assign bus.core_reset_input = i_core_reset;
    assign bus.convert_start_input = s_q.start;
    assign bus.cs_n = i_cs_n;
    assign bus.cfg_word = s_q.cfg;
    assign bus.cfg_write = s_q.cfg_wr;
    // strap low only once reference enable is cleared in the word sent
    assign bus.ref_input_pin_grounded = i_ext_ref & ~s_q.cfg[`AMC_INT_REF_EN_BIT]; // R3
    // outside drive waits for the buffer to be off, avoiding contention
    assign bus.ext_ref_drive = i_ext_ref & ~bus.ref_buffer_on; // R4
    assign o_trusted = (s_q.st == amc_pkg::HST_RUN);
    assign o_data = s_q.data;
    assign o_data_valid = s_q.data_valid;
endmodule

//--- amc_monitor.sv
// assertions on the wires between host and converter control
`timescale 1ns/10ps
module amc_monitor (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic power_down_input,
    input wire logic core_reset_input,
    input wire logic convert_start_input,
    input wire logic ref_input_pin_grounded,
    input wire logic ext_ref_drive,
    input wire logic busy,
    input wire logic result_valid,
    input wire logic sdo_oe,
    input wire logic ready,
    input wire logic bandgap_on,
    input wire logic ref_buffer_on,
    input wire logic regulators_on
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_b);

    // busy length counter; too short to wrap for either mode
    logic [5:0] blen_q;
    logic [5:0] blen_d;
    always_comb blen_d = busy ? blen_q + 6'h01 : 6'h00;
    always_ff @(posedge i_sys_clk) blen_q <= blen_d;

    chk_sleep_quiet: assert property (power_down_input |=> !busy && !result_valid)
        else $error("busy or result during power down");
    chk_sleep_powered: assert property (power_down_input |-> !regulators_on
        && !bandgap_on && !ref_buffer_on) else $error("supplies on in sleep");
    chk_abort_sdo: assert property (power_down_input || core_reset_input |-> !sdo_oe)
        else $error("data output enabled in sleep or reset");
    chk_bgap_buffer: assert property (regulators_on && !bandgap_on
        && !ref_input_pin_grounded |-> ref_buffer_on) else $error("buffer off");
    chk_ext_buffer: assert property (ref_input_pin_grounded && !bandgap_on
        |-> !ref_buffer_on) else $error("buffer on with grounded input");
    chk_no_contend: assert property (ext_ref_drive |-> !ref_buffer_on)
        else $error("external drive against buffer");
    chk_start_taken: assert property ($rose(convert_start_input) && ready && !busy
        && !power_down_input && !core_reset_input |=> busy) else $error("start lost");
    chk_settle_ignore: assert property (!ready && !busy |=> !busy)
        else $error("start taken before ready");
    chk_wake_reset: assert property ($fell(power_down_input)
        |=> (!ready && !result_valid) [*3]) else $error("no settle after wake");
    chk_sleep_level: assert property (power_down_input [*2] |-> !busy && !result_valid)
        else $error("activity while held asleep");
    chk_busy_len: assert property ($fell(busy) && !$past(power_down_input)
        && !$past(core_reset_input) |-> blen_q == 6'h12 || blen_q == 6'h0f)
        else $error("busy length wrong");
endmodule

//--- adc_power_reference_mode_ctrl_test.sv
// self-checking bench: host and converter control joined by their interface
`timescale 1ns/10ps
module adc_power_reference_mode_ctrl_test;
    logic i_sys_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic sleep_r = 1'b0;
    logic crst_r = 1'b0;
    logic req_r = 1'b0;
    logic [15:0] cfg_r = 16'h0006;
    logic cfg_wr_r = 1'b0;
    logic ext_r = 1'b0;
    logic cs_n_r = 1'b0;
    logic trusted;
    logic [15:0] data;
    logic data_valid;
    logic sleeping;
    logic [15:0] cfg_act;
    int fail_count = 0;
    int n_compared = 0;
    int cycles = 0;
    int len;

    amc_if bif();
    // short counts keep the run brief
    amc_dev #(.BIAS_CYC(2), .REF_SETTLE_CYC(4), .WARP_MAX_CYC(20)) amc_dev_i (
        .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .bus(bif),
        .o_sleeping(sleeping), .o_cfg_active(cfg_act));
    amc_host #(.WARP_KEEP_CYC(10)) amc_host_i (
        .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .bus(bif),
        .i_sleep(sleep_r), .i_core_reset(crst_r), .i_conv_req(req_r),
        .i_cfg(cfg_r), .i_cfg_wr(cfg_wr_r), .i_ext_ref(ext_r), .i_cs_n(cs_n_r),
        .o_trusted(trusted), .o_data(data), .o_data_valid(data_valid));
    amc_monitor amc_monitor_i (
        .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
        .power_down_input(bif.power_down_input), .core_reset_input(bif.core_reset_input),
        .convert_start_input(bif.convert_start_input),
        .ref_input_pin_grounded(bif.ref_input_pin_grounded),
        .ext_ref_drive(bif.ext_ref_drive), .busy(bif.busy),
        .result_valid(bif.result_valid), .sdo_oe(bif.sdo_oe), .ready(bif.ready),
        .bandgap_on(bif.bandgap_on), .ref_buffer_on(bif.ref_buffer_on),
        .regulators_on(bif.regulators_on));

    always #20 i_sys_clk = ~i_sys_clk;

    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // run takes under four hundred cycles
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            complete_run();
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask

    task automatic wait_trusted();
        int k;
        for (k = 0; k < 400 && trusted !== 1'b1; k++) @(posedge i_sys_clk);
        #1;
    endtask

    // hold the request until the host launches it; a keep-alive may go first
    task automatic start_conv();
        int k;
        @(posedge i_sys_clk) req_r <= 1'b1;
        for (k = 0; k < 200; k++) begin
            @(posedge i_sys_clk);
            #1;
            if (bif.convert_start_input === 1'b1) break;
        end
        @(posedge i_sys_clk) req_r <= 1'b0;
        #1;
    endtask

    // count settled samples that see busy high, return once it falls
    task automatic wait_eoc(output int n);
        int k;
        n = 0;
        for (k = 0; k < 40 && bif.busy !== 1'b1; k++) begin
            @(posedge i_sys_clk);
            #1;
        end
        while (bif.busy === 1'b1 && n < 40) begin
            n++;
            @(posedge i_sys_clk);
            #1;
        end
    endtask

    // one requested conversion; its result reaches the user a cycle later
    task automatic run_conv(output int n);
        start_conv();
        wait_eoc(n);
        @(posedge i_sys_clk);
        #1;
        check(data_valid, 1'b1);
        check(data, bif.result);
    endtask

    task automatic t_boot();
        wait_trusted();
        check(trusted, 1'b1);
        check(cfg_act, 16'h0006);
        check(bif.bandgap_on, 1'b1);
        check(bif.ref_buffer_on, 1'b1);
    endtask

    task automatic t_normal();
        run_conv(len);
        check(len[15:0], 16'h0012);
        check(bif.result_valid, 1'b1);
    endtask

    task automatic t_pipeline();
        @(posedge i_sys_clk) begin
            cfg_r <= 16'h0000;
            cfg_wr_r <= 1'b1;
        end
        @(posedge i_sys_clk) cfg_wr_r <= 1'b0;
        // warp word in the host starts keep-alives, which supply the two ends
        wait_eoc(len);
        check(cfg_act, 16'h0006);
        wait_eoc(len);
        check(cfg_act, 16'h0000);
        check(bif.bandgap_on, 1'b0);
        check(bif.ref_buffer_on, 1'b1);
        run_conv(len);
        check(len[15:0], 16'h000f);
        // idle longer than the warp limit; keep-alive starts must cover it
        tick(60);
        run_conv(len);
        check(bif.warp_late, 1'b0);
    endtask

    task automatic t_ext_ref();
        @(posedge i_sys_clk) ext_r <= 1'b1;
        tick(4);
        check(bif.ref_input_pin_grounded, 1'b1);
        check(bif.ref_buffer_on, 1'b0);
        check(bif.ext_ref_drive, 1'b1);
        @(posedge i_sys_clk) ext_r <= 1'b0;
        tick(4);
        check(bif.ext_ref_drive, 1'b0);
        check(bif.ref_buffer_on, 1'b1);
    endtask

    task automatic t_core_reset();
        start_conv();
        tick(4);
        check(bif.busy, 1'b1);
        @(posedge i_sys_clk) crst_r <= 1'b1;
        tick(2);
        check(bif.busy, 1'b0);
        check(bif.sdo_oe, 1'b0);
        check(cfg_act, 16'h0006);
        @(posedge i_sys_clk) crst_r <= 1'b0;
        tick(30);
    endtask

    task automatic t_power_down();
        @(posedge i_sys_clk) sleep_r <= 1'b1;
        tick(3);
        @(posedge i_sys_clk) req_r <= 1'b1;
        @(posedge i_sys_clk) req_r <= 1'b0;
        tick(5);
        check(bif.busy, 1'b0);
        check(sleeping, 1'b1);
        check(bif.sdo_oe, 1'b0);
        check(bif.regulators_on, 1'b0);
        check(bif.bandgap_on, 1'b0);
        @(posedge i_sys_clk) sleep_r <= 1'b0;
        tick(2);
        check(cfg_act, 16'h0006);
        check(bif.ready, 1'b0);
        wait_trusted();
        check(cfg_act, 16'h0000);
    endtask

    initial begin
        repeat (2) @(posedge i_sys_clk);
        i_rst_b <= 1'b1;
        t_boot();
        t_normal();
        t_pipeline();
        t_ext_ref();
        t_core_reset();
        t_power_down();
        complete_run();
    end
endmodule
